/* core/obc_top.sv */
//==========================================================
// Purpose: breaker object control, one 3-pole breaker and cart
// Assumes: all inputs synchronous to mclk
// Notes:   one log entry written per cycle; extra events wait
//==========================================================
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module obc_top #(
  parameter int unsigned TICK_CYC = obc_pkg::TICK_CYC
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic [obc_pkg::AW-1:0]   addr,
  input  wire logic [obc_pkg::DW-1:0]   wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [obc_pkg::DW-1:0]   rdata,
  input  wire logic [2:0]               open_st,
  input  wire logic [2:0]               close_st,
  input  wire logic                     cart_in,
  input  wire logic                     cart_out,
  input  wire logic                     ready_in,
  input  wire logic                     sync_in,
  input  wire logic                     loc_open,
  input  wire logic                     loc_close,
  input  wire logic                     rem_open,
  input  wire logic                     rem_close,
  input  wire logic                     app_open_abc,
  input  wire logic [2:0]               app_open_ph,
  input  wire logic                     app_close,
  input  wire logic                     disp_open,
  input  wire logic                     disp_close,
  input  wire logic [1:0]               disp_level,
  input  wire logic                     open_block,
  input  wire logic                     close_block,
  input  wire logic                     reclose_pend,
  output logic      [2:0]               open_cmd,
  output logic                          close_cmd,
  output logic                          final_trip,
  output logic                          obj_ready,
  output logic                          sync_ok,
  output logic      [7:0]               obj_status
);
  import obc_pkg::*;

  //========================================================
  // Millisecond tick and time stamp
  logic [TW-1:0] tdiv_q;
  logic          tick_q;
  logic [31:0]   ms_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tdiv_q <= '0;
      tick_q <= 1'b0;
      ms_q   <= '0;
    end else begin
      tick_q <= 1'b0;
      if (tdiv_q == TW'(TICK_CYC - 1)) begin
        tdiv_q <= '0;
        tick_q <= 1'b1;
        ms_q   <= ms_q + 32'h0000_0001;
      end else begin
        tdiv_q <= tdiv_q + 1'b1;
      end
    end
  end

  //========================================================
  // Settings registers
  logic [TW-1:0]  trav_q, clmax_q, opmax_q, term_q, ftlen_q;
  logic [3:0]     ctrl_q;
  logic [NEV-1:0] rise_en_q, fall_en_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trav_q    <= TRAV_DEF;
      clmax_q   <= CLMAX_DEF;
      opmax_q   <= OPMAX_DEF;
      term_q    <= TERM_DEF;
      ftlen_q   <= FTLEN_DEF;
      ctrl_q    <= {2'b00, ACC_DEF};
      rise_en_q <= '1;
      fall_en_q <= '1;
    end else if (wr) begin
      case (addr)
        A_TRAV:  trav_q    <= wdata[TW-1:0];
        A_CLMAX: clmax_q   <= wdata[TW-1:0];
        A_OPMAX: opmax_q   <= wdata[TW-1:0];
        A_TERM:  term_q    <= wdata[TW-1:0];
        A_FTLEN: ftlen_q   <= wdata[TW-1:0];
        A_CTRL:  ctrl_q    <= wdata[3:0];
        A_RISE:  rise_en_q <= wdata[NEV-1:0];
        A_FALL:  fall_en_q <= wdata[NEV-1:0];
        default: ;
      endcase
    end
  end

  //========================================================
  // Status decode: phases 0..2, cart 3
  logic [3:0]      raw_op, raw_cl;
  logic [3:0][1:0] stat_q;
  logic [TW-1:0]   ttr_q [4];
  logic [15:0]     st_oh;

  assign raw_op = {cart_out, open_st};
  assign raw_cl = {cart_in, close_st};

  for (genvar g = 0; g < 4; g++) begin : g_stat
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        stat_q[g] <= ST_INT;
        ttr_q[g]  <= '0;
      end else if (raw_op[g] ^ raw_cl[g]) begin
        stat_q[g] <= {raw_cl[g], raw_op[g]};
        ttr_q[g]  <= '0;
      end else if (ttr_q[g] >= trav_q) begin
        // Both high gives Bad, both low Intermediate
        stat_q[g] <= {raw_cl[g], raw_op[g]};
      end else if (tick_q) begin
        ttr_q[g] <= ttr_q[g] + 1'b1;
      end
    end
    assign st_oh[g*4 +: 4] = 4'b0001 << stat_q[g];
  end

  //========================================================
  // Command sources, blocking and edge detect
  logic       disp_ok, op_blk, cl_blk;
  logic [2:0] op_req, op_prev_q, start_op;
  logic       cl_req, cl_prev_q, start_cl;

  assign disp_ok = disp_level >= ctrl_q[1:0];
  // Blocking is sampled in the start cycle, and close blocking also in CL_WAIT,
  // so it must already be settled when the command edge arrives
  assign op_blk = open_block | ctrl_q[C_SWBO];
  assign cl_blk = close_block | ctrl_q[C_SWBC];
  assign op_req = {3{loc_open | rem_open | app_open_abc |
                     (disp_open & disp_ok)}} | app_open_ph;
  assign cl_req = loc_close | rem_close | app_close |
                  (disp_close & disp_ok);
  assign start_op = op_req & ~op_prev_q & {3{~op_blk}};
  assign start_cl = cl_req & ~cl_prev_q & ~cl_blk;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_prev_q <= '0;
      cl_prev_q <= 1'b0;
      obj_ready <= 1'b0;
      sync_ok   <= 1'b0;
    end else begin
      op_prev_q <= op_req;
      cl_prev_q <= cl_req;
      obj_ready <= ready_in;
      sync_ok   <= sync_in;
    end
  end

  //========================================================
  // Open control per phase
  logic [2:0]    op_act_q, opto_q;
  logic [TW-1:0] op_t_q [3];

  for (genvar p = 0; p < 3; p++) begin : g_open
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        op_act_q[p] <= 1'b0;
        open_cmd[p] <= 1'b0;
        opto_q[p]   <= 1'b0;
        op_t_q[p]   <= '0;
      end else if (start_op[p]) begin
        op_act_q[p] <= 1'b1;
        open_cmd[p] <= 1'b1;
        opto_q[p]   <= 1'b0;
        op_t_q[p]   <= '0;
      end else if (op_act_q[p]) begin
        if (stat_q[p] == ST_OPEN) begin
          op_act_q[p] <= 1'b0;
          open_cmd[p] <= 1'b0;
        end else if (op_t_q[p] >= term_q) begin
          op_act_q[p] <= 1'b0;
          open_cmd[p] <= 1'b0;
          opto_q[p]   <= 1'b1;
        end else begin
          if (op_t_q[p] >= opmax_q)
            open_cmd[p] <= 1'b0;
          if (tick_q)
            op_t_q[p] <= op_t_q[p] + 1'b1;
        end
      end
    end
  end

  //========================================================
  // Close control with ready and sync wait
  obc_cl_t       cl_st_q;
  logic          clto_q;
  logic [TW-1:0] cl_t_q;
  logic          all_cl, all_op, cl_go;

  assign all_cl = (stat_q[0] == ST_CLOSE) && (stat_q[1] == ST_CLOSE) &&
                  (stat_q[2] == ST_CLOSE);
  assign all_op = (stat_q[0] == ST_OPEN) && (stat_q[1] == ST_OPEN) &&
                  (stat_q[2] == ST_OPEN);
  assign cl_go = obj_ready & sync_ok;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cl_st_q   <= CL_IDLE;
      close_cmd <= 1'b0;
      clto_q    <= 1'b0;
      cl_t_q    <= '0;
    end else begin
      case (cl_st_q)
        CL_IDLE: begin
          if (start_cl) begin
            clto_q <= 1'b0;
            cl_t_q <= '0;
            if (cl_go) begin
              cl_st_q   <= CL_ACT;
              close_cmd <= 1'b1;
            end else begin
              cl_st_q <= CL_WAIT;
            end
          end
        end
        CL_WAIT: begin
          // An open command or new blocking cancels the pending close
          if (|start_op || cl_blk) begin
            cl_st_q <= CL_IDLE;
          end else if (cl_go) begin
            cl_st_q   <= CL_ACT;
            close_cmd <= 1'b1;
          end
        end
        CL_ACT: begin
          if (all_cl) begin
            cl_st_q   <= CL_IDLE;
            close_cmd <= 1'b0;
          end else if (cl_t_q >= term_q) begin
            cl_st_q   <= CL_IDLE;
            close_cmd <= 1'b0;
            clto_q    <= 1'b1;
          end else begin
            if (cl_t_q >= clmax_q)
              close_cmd <= 1'b0;
            if (tick_q)
              cl_t_q <= cl_t_q + 1'b1;
          end
        end
        default: begin
          cl_st_q   <= CL_IDLE;
          close_cmd <= 1'b0;
        end
      endcase
    end
  end

  //========================================================
  // Final trip
  logic          ft_arm_q;
  logic [TW-1:0] ft_t_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ft_arm_q   <= 1'b0;
      final_trip <= 1'b0;
      ft_t_q     <= '0;
    end else if (start_cl) begin
      ft_arm_q   <= 1'b0;
      final_trip <= 1'b0;
    end else begin
      if (|start_op)
        ft_arm_q <= 1'b1;
      else if (ft_arm_q && all_op) begin
        ft_arm_q <= 1'b0;
        if (!reclose_pend) begin
          final_trip <= 1'b1;
          ft_t_q     <= '0;
        end
      end
      if (final_trip) begin
        // Zero length keeps the trip on until the next close
        if (ftlen_q != '0 && ft_t_q >= ftlen_q)
          final_trip <= 1'b0;
        else if (tick_q)
          ft_t_q <= ft_t_q + 1'b1;
      end
    end
  end

  //========================================================
  // Event detection and selection
  logic [NEV-1:0]   lvl, lvl_prev_q, pend_r_q, pend_f_q;
  logic [2*NEV-1:0] pend, clr;
  logic             ev_hit;
  logic [5:0]       ev_code;

  // Order: statuses, open cmds, close cmd, blocks, ready, sync,
  // final trip, open fail, close fail, open timeouts, close timeout
  assign lvl = {clto_q, opto_q, clto_q, |opto_q, final_trip,
                sync_ok, obj_ready, cl_blk, op_blk, close_cmd,
                open_cmd, st_oh};
  assign pend = {pend_f_q, pend_r_q};

  always_comb begin
    ev_hit  = 1'b0;
    ev_code = '0;
    for (int i = 2*NEV-1; i >= 0; i--) begin
      if (pend[i]) begin
        ev_hit  = 1'b1;
        ev_code = 6'(i);
      end
    end
  end

  assign clr = ev_hit ? ((2*NEV)'(1) << ev_code) : '0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Statuses reset to Intermediate: no false edge at release
      lvl_prev_q <= NEV'({4{4'b0001 << ST_INT}});
      pend_r_q   <= '0;
      pend_f_q   <= '0;
    end else begin
      lvl_prev_q <= lvl;
      // A new edge wins over the clear of the same bit
      pend_r_q <= (pend_r_q & ~clr[NEV-1:0]) |
                  (lvl & ~lvl_prev_q & rise_en_q);
      pend_f_q <= (pend_f_q & ~clr[2*NEV-1:NEV]) |
                  (~lvl & lvl_prev_q & fall_en_q);
    end
  end

  //========================================================
  // Operation log, twelve newest entries
  logic [45:0] log_mem [LOGN];
  logic [3:0]  wptr_q, cnt_q;

  always_ff @(posedge mclk) begin
    if (ev_hit)
      log_mem[wptr_q] <= {ms_q, ev_code, stat_q};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wptr_q <= '0;
      cnt_q  <= '0;
    end else if (ev_hit) begin
      wptr_q <= (wptr_q == 4'(LOGN - 1)) ? '0 : wptr_q + 1'b1;
      if (cnt_q != 4'(LOGN))
        cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      obj_status <= '0;
    else
      obj_status <= stat_q;
  end

  //========================================================
  // Register read
  logic [AW-1:0] loff;
  logic [3:0]    lidx;

  assign loff = addr - A_LOG;
  assign lidx = loff[6:3];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        A_TRAV:  rdata <= DW'(trav_q);
        A_CLMAX: rdata <= DW'(clmax_q);
        A_OPMAX: rdata <= DW'(opmax_q);
        A_TERM:  rdata <= DW'(term_q);
        A_FTLEN: rdata <= DW'(ftlen_q);
        A_CTRL:  rdata <= DW'(ctrl_q);
        A_RISE:  rdata <= DW'(rise_en_q);
        A_FALL:  rdata <= DW'(fall_en_q);
        A_STAT:  rdata <= {10'h000, cl_st_q, opto_q, clto_q,
                           final_trip, sync_ok, obj_ready,
                           close_cmd, open_cmd, stat_q};
        A_LPTR:  rdata <= {24'h00_0000, cnt_q, wptr_q};
        default: begin
          if (addr >= A_LOG && addr < A_LEND && addr[1:0] == 2'b00)
            rdata <= loff[2] ? DW'(log_mem[lidx][13:0])
                             : log_mem[lidx][45:14];
          else
            rdata <= '0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* core/obc_pkg.sv */
//==========================================================
// Purpose: constants for the breaker object control block
// Assumes: 125 MHz function clock, 1 ms timer tick
// Notes:   settings registers hold times in milliseconds
//==========================================================
// Summary of operation
// - After traverse time, both status inputs active means phase Bad.
// - After traverse time, neither status input active means Intermediate.
// - Close pulse capped at its maximum, ends early when all three phases read Closed.
// - Open pulse capped at its own maximum, ends early on new state.
// - Shared termination timeout ends control and raises an error.
// - Final trip held for pulse length; zero length means continuous.
// - Final trip only when no automatic reclose is expected.
// - Display control accepted only at or above chosen access level.
// - Commands from local, remote, application; application open per phase.
// - Separate blocking and interlock for open and for close.
// - Per-event choice to store rising, falling or both events.
// - Every event carries a time stamp taken when it is written to the log.
// - On and off events for each phase open command output.
// - Ready for closing signalled; close held pending until ready.
// - Sync condition signalled; close held pending until sync ok.
// - Separate on and off events for open and close failure.
// - Timeout event per phase open command and one for close.
// - Rolling log keeps the twelve newest time-stamped entries.
// - Log entry holds time, event, three phase statuses, cart status.
// - Logic one on a status input means that state is active.
// - Independent open pulse per phase, one close pulse output.
package obc_pkg;
  localparam int AW      = 8;
  localparam int DW      = 32;
  localparam int TW      = 20;
  localparam int NEV     = 31;
  localparam int LOGN    = 12;
  localparam int CLK_HZ  = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [TW-1:0] TRAV_DEF  = 20'h0_00C8;
  localparam logic [TW-1:0] CLMAX_DEF = 20'h0_00C8;
  localparam logic [TW-1:0] OPMAX_DEF = 20'h0_00C8;
  localparam logic [TW-1:0] TERM_DEF  = 20'h0_2710;
  localparam logic [TW-1:0] FTLEN_DEF = 20'h0_00C8;
  localparam logic [1:0] ACC_DEF = 2'h2;
  localparam logic [AW-1:0] A_TRAV  = 8'h00;
  localparam logic [AW-1:0] A_CLMAX = 8'h04;
  localparam logic [AW-1:0] A_OPMAX = 8'h08;
  localparam logic [AW-1:0] A_TERM  = 8'h0C;
  localparam logic [AW-1:0] A_FTLEN = 8'h10;
  localparam logic [AW-1:0] A_CTRL  = 8'h14;
  localparam logic [AW-1:0] A_RISE  = 8'h18;
  localparam logic [AW-1:0] A_FALL  = 8'h1C;
  localparam logic [AW-1:0] A_STAT  = 8'h20;
  localparam logic [AW-1:0] A_LPTR  = 8'h24;
  localparam logic [AW-1:0] A_LOG   = 8'h40;
  localparam logic [AW-1:0] A_LEND  = 8'hA0;
  localparam int C_SWBO = 2;
  localparam int C_SWBC = 3;
  localparam logic [1:0] ST_INT   = 2'h0;
  localparam logic [1:0] ST_OPEN  = 2'h1;
  localparam logic [1:0] ST_CLOSE = 2'h2;
  localparam logic [1:0] ST_BAD   = 2'h3;
  typedef enum logic [2:0] {
    CL_IDLE = 3'h1,
    CL_WAIT = 3'h2,
    CL_ACT  = 3'h4
  } obc_cl_t;
endpackage

/* dv/obc_monitor.sv */
// Purpose: port checks for the breaker object control block
// Assumes: TICK_CYC equals the value of the bound instance
// Notes:   pulse bounds allow one tick of timer slack
`timescale 1ns/10ps
`default_nettype none
module obc_monitor #(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic [obc_pkg::AW-1:0] addr,
  input wire logic [obc_pkg::DW-1:0] wdata,
  input wire logic                   wr,
  input wire logic [2:0]             open_st,
  input wire logic [2:0]             close_st,
  input wire logic                   ready_in,
  input wire logic                   sync_in,
  input wire logic                   open_block,
  input wire logic                   close_block,
  input wire logic                   reclose_pend,
  input wire logic [2:0]             open_cmd,
  input wire logic                   close_cmd,
  input wire logic                   final_trip,
  input wire logic [7:0]             obj_status
);
  import obc_pkg::*;
  logic [TW-1:0] opmax_q;
  logic [TW-1:0] clmax_q;
  logic [31:0]   ocnt_q;
  logic [31:0]   ccnt_q;
  // ==========================================================
  // Shadow of the pulse limits, so bounds follow software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opmax_q <= OPMAX_DEF;
      clmax_q <= CLMAX_DEF;
    end else if (wr && addr == A_OPMAX) begin
      opmax_q <= wdata[TW-1:0];
    end else if (wr && addr == A_CLMAX) begin
      clmax_q <= wdata[TW-1:0];
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ocnt_q <= '0;
      ccnt_q <= '0;
    end else begin
      ocnt_q <= open_cmd[0] ? ocnt_q + 32'h1 : '0;
      ccnt_q <= close_cmd ? ccnt_q + 32'h1 : '0;
    end
  end
  // ==========================================================
  // Assertions
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  a_open_decode:
    assert property (open_st[0] && !close_st[0] |->
                     ##2 obj_status[1:0] == ST_OPEN)
    else $error("phase A open not decoded");
  a_close_decode:
    assert property (close_st[1] && !open_st[1] |->
                     ##2 obj_status[3:2] == ST_CLOSE)
    else $error("phase B close not decoded");
  a_open_early_end:
    assert property (open_cmd[0] && obj_status[1:0] == ST_OPEN |=> !open_cmd[0])
    else $error("open pulse kept after open");
  a_close_early_end:
    assert property (close_cmd && obj_status[5:0] == 6'h2A |=> !close_cmd)
    else $error("close pulse kept after close");
  a_open_max_len:
    assert property (ocnt_q <= (32'(opmax_q) + 32'h1) * TICK_CYC + 32'h4)
    else $error("open pulse too long");
  a_close_max_len:
    assert property (ccnt_q <= (32'(clmax_q) + 32'h1) * TICK_CYC + 32'h4)
    else $error("close pulse too long");
  a_open_unblocked:
    assert property ($rose(open_cmd[0]) |-> !$past(open_block))
    else $error("open issued while blocked");
  a_close_unblocked:
    assert property ($rose(close_cmd) |-> !$past(close_block))
    else $error("close issued while blocked");
  a_close_ready_sync:
    assert property ($rose(close_cmd) |->
                     $past(ready_in, 2) && $past(sync_in, 2))
    else $error("close issued without ready and sync");
  a_ftrip_no_reclose:
    assert property ($rose(final_trip) |-> !$past(reclose_pend))
    else $error("final trip while reclose expected");
endmodule
bind obc_top obc_monitor #(.TICK_CYC(TICK_CYC)) u_mon (.*);
`default_nettype wire

/* dv/obc_brk_model.sv */
// Purpose: breaker contacts answering the command relays
// Assumes: mode 0 prompt, 1 stuck, 2 phase A both, 3 phase A none
// Notes:   contacts travel after four cycles of command
`timescale 1ns/10ps
`default_nettype none
module obc_brk_model (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [2:0] open_cmd,
  input wire logic       close_cmd,
  input wire logic [1:0] mode,
  output logic     [2:0] open_st,
  output logic     [2:0] close_st
);
  logic [2:0] cl_q;
  logic [2:0] cnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cl_q  <= 3'h7;
      cnt_q <= 3'h0;
    end else if ((|open_cmd || close_cmd) && mode != 2'h1) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h3) begin
        cl_q  <= close_cmd ? 3'h7 : (cl_q & ~open_cmd);
        cnt_q <= 3'h0;
      end
    end else begin
      cnt_q <= 3'h0;
    end
  end
  // A one marks the active contact
  always_comb begin
    open_st  = ~cl_q;
    close_st = cl_q;
    if (mode[1]) begin
      open_st[0]  = ~mode[0];
      close_st[0] = ~mode[0];
    end
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Purpose: directed test of the breaker object control block
// Assumes: one timer tick is ten clocks, times set in ticks
// Notes:   cart moves out once near the end; log statuses follow it
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import obc_pkg::*;
  localparam int unsigned TCK = 10;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic [DW-1:0] rdata;
  logic [2:0]    open_st;
  logic [2:0]    close_st;
  logic          ready_in = 1'b1;
  logic          sync_in = 1'b1;
  logic [10:0]   cmd_v = '0;
  logic [1:0]    disp_level = 2'h1;
  logic          open_block = 1'b0;
  logic          close_block = 1'b0;
  logic          cart_in = 1'b1;
  logic          cart_out = 1'b0;
  logic          reclose_pend = 1'b0;
  logic [1:0]    mode = 2'h0;
  logic [2:0]    open_cmd;
  logic          close_cmd;
  logic          final_trip;
  logic          obj_ready;
  logic          sync_ok;
  logic [7:0]    obj_status;
  logic [DW-1:0] d;
  logic [DW-1:0] t0;
  int            s;
  int            n_fail = 0;
  int            checked = 0;
  always #4 mclk = ~mclk;
  obc_top #(.TICK_CYC(TCK)) dut (.*, .loc_open(cmd_v[0]),
    .loc_close(cmd_v[1]),
    .rem_open(cmd_v[2]), .rem_close(cmd_v[3]), .app_open_abc(cmd_v[4]),
    .app_close(cmd_v[5]), .disp_open(cmd_v[6]), .disp_close(cmd_v[7]),
    .app_open_ph(cmd_v[10:8]));
  obc_brk_model bm (.mclk, .rst, .open_cmd, .close_cmd, .mode, .open_st,
    .close_st);
  // ==========================================================
  // Access and compare tasks
  task automatic chk(input string n, input logic [DW-1:0] e,
                     input logic [DW-1:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Data appear in the cycle after the strobe and hold until the next read
  task automatic rd_reg(input logic [AW-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] m,
                        input logic [DW-1:0] e);
    rd_reg(a);
    chk($sformatf("reg %h", a), e, d & m);
  endtask
  task automatic pulse(input int b);
    @(posedge mclk);
    cmd_v[b] <= 1'b1;
    @(posedge mclk);
    cmd_v[b] <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (9000) @(posedge mclk);
    n_fail++;
    $display("FAIL watchdog expected finish seen hang");
    stop_test();
  end
  // ==========================================================
  // Directed sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(A_TRAV, 32'hF_FFFF, 32'(TRAV_DEF));
    rd_chk(A_CLMAX, 32'hF_FFFF, 32'(CLMAX_DEF));
    rd_chk(A_OPMAX, 32'hF_FFFF, 32'(OPMAX_DEF));
    rd_chk(A_TERM, 32'hF_FFFF, 32'(TERM_DEF));
    rd_chk(A_FTLEN, 32'hF_FFFF, 32'(FTLEN_DEF));
    rd_chk(A_CTRL, 32'h0000_0003, 32'(ACC_DEF));
    rd_chk(A_FALL, 32'hFFFF_FFFF, 32'h7FFF_FFFF);
    rd_chk(8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
    wr_reg(A_TRAV, 32'h0000_0005);
    wr_reg(A_OPMAX, 32'h0000_0014);
    wr_reg(A_CLMAX, 32'h0000_0014);
    wr_reg(A_TERM, 32'h0000_0028);
    wr_reg(A_FTLEN, 32'h0000_0008);
    chk("status", 32'h0000_00AA, 32'(obj_status));
    pulse(6);
    wt(2);
    chk("low level", 32'h0, 32'(open_cmd));
    @(posedge mclk) open_block <= 1'b1;
    wt(60);
    pulse(0);
    wt(2);
    chk("pin block", 32'h0, 32'(open_cmd));
    @(posedge mclk) open_block <= 1'b0;
    wr_reg(A_CTRL, 32'h0000_0006);
    wt(60);
    pulse(2);
    wt(2);
    chk("soft block", 32'h0, 32'(open_cmd));
    wr_reg(A_CTRL, 32'h0000_0002);
    @(posedge mclk) disp_level <= 2'h2;
    pulse(6);
    wt(1);
    chk("open all", 32'h7, 32'(open_cmd));
    wt(10);
    chk("status", 32'h0000_0095, 32'(obj_status));
    chk("open end", 32'h0, 32'(open_cmd));
    chk("ftrip", 32'h1, 32'(final_trip));
    wt(40);
    chk("ftrip", 32'h1, 32'(final_trip));
    wt(60);
    chk("ftrip", 32'h0, 32'(final_trip));
    @(posedge mclk) close_block <= 1'b1;
    wt(60);
    pulse(1);
    wt(2);
    chk("close block", 32'h0, 32'(close_cmd));
    @(posedge mclk) close_block <= 1'b0;
    @(posedge mclk) ready_in <= 1'b0;
    pulse(1);
    wt(5);
    chk("close wait", 32'h0, 32'(close_cmd));
    chk("ready", 32'h0, 32'(obj_ready));
    rd_chk(A_STAT, 32'h0038_0000, 32'h0010_0000);
    @(posedge mclk) ready_in <= 1'b1;
    wt(3);
    chk("close go", 32'h1, 32'(close_cmd));
    wt(12);
    chk("status", 32'h0000_00AA, 32'(obj_status));
    chk("close end", 32'h0, 32'(close_cmd));
    @(posedge mclk) reclose_pend <= 1'b1;
    pulse(4);
    wt(12);
    chk("status", 32'h0000_0095, 32'(obj_status));
    chk("ftrip", 32'h0, 32'(final_trip));
    @(posedge mclk) sync_in <= 1'b0;
    pulse(5);
    wt(5);
    chk("close wait", 32'h0, 32'(close_cmd));
    chk("sync", 32'h0, 32'(sync_ok));
    @(posedge mclk) sync_in <= 1'b1;
    wt(3);
    chk("close go", 32'h1, 32'(close_cmd));
    wt(12);
    @(posedge mclk) reclose_pend <= 1'b0;
    pulse(9);
    wt(1);
    chk("open B", 32'h2, 32'(open_cmd));
    wt(12);
    chk("status", 32'h0000_00A6, 32'(obj_status));
    pulse(3);
    wt(12);
    chk("status", 32'h0000_00AA, 32'(obj_status));
    @(posedge mclk) mode <= 2'h1;
    pulse(0);
    wt(170);
    chk("open max", 32'h7, 32'(open_cmd));
    wt(55);
    chk("open max", 32'h0, 32'(open_cmd));
    wt(200);
    rd_chk(A_STAT, 32'h0007_0000, 32'h0007_0000);
    @(posedge mclk) mode <= 2'h0;
    pulse(0);
    wt(12);
    @(posedge mclk) mode <= 2'h1;
    pulse(1);
    wt(430);
    rd_chk(A_STAT, 32'h0000_8000, 32'h0000_8000);
    @(posedge mclk) mode <= 2'h0;
    pulse(1);
    wt(12);
    wr_reg(A_FALL, 32'h0000_0000);
    @(posedge mclk) cart_in <= 1'b0;
    cart_out <= 1'b1;
    wt(3);
    chk("cart", 32'(ST_OPEN), 32'(obj_status[7:6]));
    @(posedge mclk) mode <= 2'h2;
    wt(20);
    chk("A early", 32'(ST_CLOSE), 32'(obj_status[1:0]));
    wt(60);
    chk("A bad", 32'(ST_BAD), 32'(obj_status[1:0]));
    @(posedge mclk) mode <= 2'h3;
    wt(80);
    chk("A int", 32'(ST_INT), 32'(obj_status[1:0]));
    rd_chk(A_LPTR, 32'h0000_00F0, 32'h0000_00C0);
    s = (int'(d[3:0]) + 11) % 12;
    rd_chk(A_LOG + 8'(8 * s + 4), 32'h3FFF, 32'h0068);
    rd_reg(A_LOG + 8'(8 * s));
    t0 = d;
    s = (s + 11) % 12;
    rd_chk(A_LOG + 8'(8 * s + 4), 32'h3FFF, 32'h036B);
    rd_reg(A_LOG + 8'(8 * s));
    chk("stamp gap", 32'h1, 32'((t0 - d) inside {[3:4]}));
    stop_test();
  end
endmodule
`default_nettype wire
